// ---- design/cbs_card_bus.sv ----
/*
 card-slot bus pin driver for areas 5 and 6, memory and I/O modes.
 assumes requests come from bus control logic on clk; pins pass a
 two-flop synchroniser; the pad ring resolves each _o/_oe pair.
*/
`timescale 1ns/100ps
`default_nettype none
module cbs_card_bus
    import cbs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire cbs_cfg_t cfg,
    input wire logic req_valid,
    input wire cbs_req_t req,
    input wire logic wait_n,
    input wire logic card_16bit_sense_n,
    input wire logic [15:0] card_data_i,
    output logic req_ready,
    output logic done,
    output logic [DATA_W-1:0] rdata,
    output cbs_pins_t pins
);
    typedef struct packed {
        cbs_state_t st;
        logic ready;
        logic done;
        logic area6;
        logic write;
        logic io_mode;
        logic bw8;
        logic [1:0] size;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [2:0] boff;
        logic [2:0] wcnt;
        logic [DATA_W-1:0] rdata;
        cbs_pins_t pins;
    } cbs_regs_t;

    cbs_regs_t r;
    cbs_regs_t n;

    logic [SYNC_W-1:0] sync_q;
    logic wait_n_s;
    logic sense_n_s;
    logic [15:0] data_s;

    cbs_sync #(
        .W(SYNC_W)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({wait_n, card_16bit_sense_n, card_data_i}),
        .q(sync_q)
    );

    assign wait_n_s = sync_q[17];
    assign sense_n_s = sync_q[16];
    assign data_s = sync_q[15:0];

    // byte position inside the host word for byte i of an access
    function automatic int byte_pos(
        input logic [1:0] size,
        input logic [2:0] i,
        input logic be
    );
        int last;
        last = (1 << size) - 1;
        if (be) begin
            return LANE_W * (last - int'(i));
        end
        return LANE_W * int'(i);
    endfunction

    // lane of a byte on the card bus from its address parity
    function automatic int lane_of(
        input logic bw8,
        input logic odd,
        input logic be
    );
        if (bw8) begin
            return 0;
        end
        return int'(odd ^ be);
    endfunction

    logic [2:0] size_bytes;
    logic [2:0] beat_bytes;
    logic last_beat;
    logic [2:0] area_wait;
    logic bus16_sel;
    logic wait_done;

    always_comb begin
        size_bytes = ONE_BYTE << r.size;
        if (r.size == SIZE_BYTE || r.bw8) begin
            beat_bytes = ONE_BYTE;
        end else begin
            beat_bytes = TWO_BYTES;
        end
        last_beat = (r.boff + beat_bytes) >= size_bytes;
        if (r.area6) begin
            area_wait = cfg.area6_wait_setting;
        end else begin
            area_wait = cfg.area5_wait_setting;
        end
        if (req.area6) begin
            bus16_sel = cfg.area6_bus16;
        end else begin
            bus16_sel = cfg.area5_bus16;
        end
        // a zero wait setting means the wait pin is not looked at
        wait_done = (area_wait == WAIT_NONE) || wait_n_s;
    end

    logic [2:0] ib;
    logic odd;
    logic odd_byte16;
    logic ce2_low;
    int pos;
    int lane;

    always_comb begin
        ib = 3'h0;
        odd = 1'b0;
        odd_byte16 = 1'b0;
        ce2_low = 1'b0;
        pos = 0;
        lane = 0;
        n = r;
        n.done = 1'b0;

        unique case (r.st)
            ST_IDLE: begin
                n.ready = 1'b1;
                if (req_valid && r.ready) begin
                    n.ready = 1'b0;
                    n.area6 = req.area6;
                    n.write = req.write;
                    n.io_mode = req.io_mode;
                    n.size = req.size;
                    n.addr = req.addr;
                    n.wdata = req.wdata;
                    n.boff = 3'h0;
                    n.rdata = '0;
                    n.bw8 = !bus16_sel;
                    // big-endian I/O on a 16-bit area: a card that does not claim 16 bits gets byte beats
                    if (bus16_sel && cfg.big_endian && req.io_mode) begin
                        n.bw8 = sense_n_s;
                    end
                    n.st = ST_SETUP;
                end
            end
            ST_SETUP: begin
                n.wcnt = area_wait;
                n.st = ST_STROBE;
            end
            ST_STROBE: begin
                if (r.wcnt != WAIT_NONE) begin
                    n.wcnt = r.wcnt - 3'h1;
                end else if (wait_done) begin
                    n.st = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // read bytes are taken at the end of the hold cycle
                if (!r.write) begin
                    for (int k = 0; k < 2; k++) begin
                        if (3'(k) < beat_bytes) begin
                            ib = r.boff + 3'(k);
                            odd = r.addr[0] ^ ib[0];
                            pos = byte_pos(r.size, ib, cfg.big_endian);
                            lane = lane_of(r.bw8, odd, cfg.big_endian);
                            n.rdata[pos +: LANE_W] = data_s[LANE_W*lane +: LANE_W];
                        end
                    end
                end
                if (last_beat) begin
                    n.st = ST_IDLE;
                    n.done = 1'b1;
                    n.ready = 1'b1;
                end else begin
                    n.boff = r.boff + beat_bytes;
                    n.st = ST_SETUP;
                end
            end
        endcase

        // pin image follows the next state so pins and state move together
        n.pins.area_chip_selects_n = '1;
        n.pins.bus_start_indication_n = 1'b1;
        n.pins.rd_n = 1'b1;
        n.pins.rdwr = 1'b1;
        n.pins.row_strobe_n = 1'b1;
        n.pins.column_strobe_low_n = 1'b1;
        n.pins.clock_enable = 1'b0;
        n.pins.first_write_lane_n = 1'b1;
        n.pins.second_write_lane_n = 1'b1;
        n.pins.io_read_strobe_n = 1'b1;
        n.pins.io_write_strobe_n = 1'b1;
        n.pins.address = n.addr + ADDR_W'(n.boff);
        n.pins.data_o = '0;
        n.pins.data_oe = '0;

        n.pins.area5_second_card_enable_o = 1'b1;
        n.pins.area5_second_card_enable_oe = cfg.area5_card_select_bit;
        n.pins.area6_second_card_enable_o = 1'b1;
        n.pins.area6_second_card_enable_oe = cfg.area6_card_select_bit;

        // second row strobe belongs to another memory type
        n.pins.second_row_strobe_o = 1'b1;
        n.pins.second_row_strobe_oe = cfg.memory_type_field == MEM_TYPE_ROW2;

        // upper lanes belong to the port unit, not to the card
        if (cfg.port_enable_bit) begin
            n.pins.data_o[LANE2_LSB +: LANE_W] = cfg.port_data;
            n.pins.data_oe[LANE2_LSB +: LANE_W] = cfg.port_control_setting;
            n.pins.data_o[TOP_PORT_LSB +: 2] = cfg.top_port_data;
            n.pins.data_oe[TOP_PORT_LSB +: 2] = 2'h3;
        end

        if (n.st != ST_IDLE) begin
            odd_byte16 = !n.bw8 && n.size == SIZE_BYTE && n.addr[0];
            ce2_low = !n.bw8 && (n.size != SIZE_BYTE || n.addr[0]);
            if (n.area6) begin
                n.pins.area_chip_selects_n[CS_AREA6] = odd_byte16;
                n.pins.area6_second_card_enable_o = !ce2_low;
                n.pins.area6_second_card_enable_oe = 1'b1;
            end else begin
                n.pins.area_chip_selects_n[CS_AREA5] = odd_byte16;
                n.pins.area5_second_card_enable_o = !ce2_low;
                n.pins.area5_second_card_enable_oe = 1'b1;
            end
            n.pins.bus_start_indication_n = n.st != ST_SETUP;
            n.pins.rdwr = !n.write;

            if (n.st == ST_STROBE) begin
                n.pins.rd_n = n.write || n.io_mode;
                n.pins.second_write_lane_n = !(n.write && !n.io_mode);
                n.pins.io_read_strobe_n = !(n.io_mode && !n.write);
                n.pins.io_write_strobe_n = !(n.io_mode && n.write);
            end

            if (n.write) begin
                n.pins.data_oe[LANE_W-1:0] = '1;
                n.pins.data_oe[LANE_W +: LANE_W] = {LANE_W{!n.bw8}};
                for (int k = 0; k < 2; k++) begin
                    if (!(n.size == SIZE_BYTE || n.bw8) || k == 0) begin
                        ib = n.boff + 3'(k);
                        odd = n.addr[0] ^ ib[0];
                        pos = byte_pos(n.size, ib, cfg.big_endian);
                        lane = lane_of(n.bw8, odd, cfg.big_endian);
                        n.pins.data_o[LANE_W*lane +: LANE_W] = n.wdata[pos +: LANE_W];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
            r.pins.area_chip_selects_n <= '1;
            r.pins.bus_start_indication_n <= 1'b1;
            r.pins.rd_n <= 1'b1;
            r.pins.rdwr <= 1'b1;
            r.pins.row_strobe_n <= 1'b1;
            r.pins.column_strobe_low_n <= 1'b1;
            r.pins.first_write_lane_n <= 1'b1;
            r.pins.second_write_lane_n <= 1'b1;
            r.pins.io_read_strobe_n <= 1'b1;
            r.pins.io_write_strobe_n <= 1'b1;
            r.pins.area5_second_card_enable_o <= 1'b1;
            r.pins.area6_second_card_enable_o <= 1'b1;
            r.pins.second_row_strobe_o <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign req_ready = r.ready;
    assign done = r.done;
    assign rdata = r.rdata;
    assign pins = r.pins;
endmodule
`default_nettype wire

// ---- design/cbs_pkg.sv ----
/*
 card-slot bus pin driver: shared constants, states and carrier types.
 assumes one 20 MHz clock and an active-low asynchronous reset.
*/
package cbs_pkg;
    localparam int ADDR_W = 26;
    localparam int DATA_W = 32;
    localparam int CS_W = 7;
    localparam int CS_AREA5 = 5;
    localparam int CS_AREA6 = 6;
    localparam int LANE_W = 8;
    localparam int LANE2_LSB = 16;
    localparam int TOP_PORT_LSB = 30;
    localparam int SYNC_W = 18;
    localparam logic [2:0] MEM_TYPE_ROW2 = 3'h5;
    localparam logic [2:0] WAIT_NONE = 3'h0;
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_LONG = 2'h2;
    localparam logic [2:0] ONE_BYTE = 3'h1;
    localparam logic [2:0] TWO_BYTES = 3'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SETUP = 2'b01,
        ST_STROBE = 2'b10,
        ST_HOLD = 2'b11
    } cbs_state_t;

    typedef struct packed {
        logic area5_bus16;
        logic area6_bus16;
        logic big_endian;
        logic area5_card_select_bit;
        logic area6_card_select_bit;
        logic [2:0] memory_type_field;
        logic port_enable_bit;
        logic [7:0] port_control_setting;
        logic [7:0] port_data;
        logic [1:0] top_port_data;
        logic [2:0] area5_wait_setting;
        logic [2:0] area6_wait_setting;
    } cbs_cfg_t;

    typedef struct packed {
        logic area6;
        logic write;
        logic io_mode;
        logic [1:0] size;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } cbs_req_t;

    typedef struct packed {
        logic [CS_W-1:0] area_chip_selects_n;
        logic bus_start_indication_n;
        logic rd_n;
        logic rdwr;
        logic row_strobe_n;
        logic column_strobe_low_n;
        logic first_write_lane_n;
        logic second_write_lane_n;
        logic io_read_strobe_n;
        logic io_write_strobe_n;
        logic area5_second_card_enable_o;
        logic area5_second_card_enable_oe;
        logic area6_second_card_enable_o;
        logic area6_second_card_enable_oe;
        logic second_row_strobe_o;
        logic second_row_strobe_oe;
        logic clock_enable;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] data_o;
        logic [DATA_W-1:0] data_oe;
    } cbs_pins_t;
endpackage

// ---- design/cbs_sync.sv ----
/*
 two-stage synchroniser for pin inputs.
 assumes the inputs idle high; reset loads ones.
*/
`timescale 1ns/100ps
`default_nettype none
module cbs_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } cbs_sync_regs_t;

    cbs_sync_regs_t r;
    cbs_sync_regs_t nxt;

    // first stage feeds only the second stage
    always_comb begin
        nxt = r;
        nxt.meta = d;
        nxt.stable = r.meta;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '1;
        end else begin
            r <= nxt;
        end
    end

    assign q = r.stable;
endmodule
`default_nettype wire

// ---- sim/cbs_card_bus_asserts.sv ----
/* checker for the card bus pin driver.
   assumes it is bound onto cbs_card_bus and sees its ports only. */
`timescale 1ns/100ps
`default_nettype none
module cbs_card_bus_chk
    import cbs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire cbs_cfg_t cfg,
    input wire logic req_valid,
    input wire cbs_req_t req,
    input wire logic req_ready,
    input wire logic done,
    input wire cbs_pins_t pins
);
    default clocking dflt @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic acc5;
    logic acc6;
    assign acc5 = req_valid && req_ready && !req.area6 && !req.io_mode;
    assign acc6 = req_valid && req_ready && req.area6;
    a_quiet_strobes: assert property (
        pins.row_strobe_n && pins.column_strobe_low_n && !pins.clock_enable
        && pins.first_write_lane_n)
        else $error("dram strobe or clock enable active");
    a_read_dir: assert property (!pins.rd_n || !pins.io_read_strobe_n |-> pins.rdwr)
        else $error("read strobe without read direction");
    a_write_dir: assert property (
        !pins.second_write_lane_n || !pins.io_write_strobe_n |-> !pins.rdwr && pins.rd_n)
        else $error("write strobe without write direction");
    a_io_exclusive: assert property (!pins.io_read_strobe_n |->
        pins.rd_n && pins.io_write_strobe_n && pins.second_write_lane_n)
        else $error("io read strobe overlaps another strobe");
    a_odd_cs_high: assert property (
        acc5 && cfg.area5_bus16 && req.size == SIZE_BYTE && req.addr[0]
        |=> pins.area_chip_selects_n[5] [*5]) else $error("odd byte asserted select");
    a_start_addr: assert property ($fell(req_ready) |->
        !pins.bus_start_indication_n && pins.address == $past(req.addr))
        else $error("bus start or address missing");
    a_ce2a_word: assert property (
        acc5 && cfg.area5_bus16 && req.size != SIZE_BYTE |-> ##[1:2]
        (!pins.area5_second_card_enable_o && pins.area5_second_card_enable_oe))
        else $error("area 5 second enable not low");
    a_ce2b_narrow: assert property (
        acc6 && !cfg.area6_bus16 |=> pins.area6_second_card_enable_o [*5])
        else $error("area 6 second enable low on narrow bus");
    a_no_wait: assert property (
        acc5 && cfg.area5_wait_setting == WAIT_NONE && req.size == SIZE_BYTE
        |-> ##[4:5] done) else $error("wait honoured with zero setting");
    a_row2_pin: assert property ($past(rst_n) |->
        pins.second_row_strobe_oe == ($past(cfg.memory_type_field) == MEM_TYPE_ROW2)
        && (!pins.second_row_strobe_oe || pins.second_row_strobe_o))
        else $error("second row strobe wrong");
    a_port_lanes: assert property ($past(rst_n) |->
        pins.data_oe[31:16] == {{2{$past(cfg.port_enable_bit)}}, 6'h00,
        ($past(cfg.port_enable_bit) ? $past(cfg.port_control_setting) : 8'h00)})
        else $error("port lane enables wrong");
    c_io_write: cover property (!pins.io_write_strobe_n);
    c_be_io: cover property (acc6 && req.io_mode && cfg.big_endian);
    c_odd_byte: cover property ($fell(req_ready) && pins.area_chip_selects_n[5]);
endmodule
bind cbs_card_bus cbs_card_bus_chk chk_u (.clk(clk), .rst_n(rst_n), .cfg(cfg),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .done(done), .pins(pins));
`default_nettype wire

// ---- sim/cbs_card_model.sv ----
/* behavioural card in the slot.
   assumes pins come straight from cbs_card_bus; stall and wide_io set by the bench. */
`timescale 1ns/100ps
`default_nettype none
module cbs_card_model
    import cbs_pkg::*;
(
    input wire logic clk,
    input wire cbs_pins_t pins,
    input wire logic [3:0] stall,
    input wire logic wide_io,
    output var logic wait_n,
    output logic card_16bit_sense_n,
    output logic [15:0] card_data_i,
    output var logic [15:0] last_wr,
    output var logic [15:0] last_oe
);
    logic [3:0] cnt = 4'h0;
    logic [15:0] junk = 16'h0000;
    logic sel;
    initial wait_n = 1'b1;
    // data offered from select on: the bus side sees it two flops late
    assign sel = pins.rdwr && (pins.area_chip_selects_n[6:5] != 2'b11
        || !pins.area5_second_card_enable_o || !pins.area6_second_card_enable_o);
    assign card_data_i = sel ? {8'hC3 ^ pins.address[7:0], 8'h3C ^ pins.address[7:0]} : junk;
    assign card_16bit_sense_n = !wide_io;
    always @(posedge clk) begin
        junk <= ~junk;
        cnt <= !pins.bus_start_indication_n ? stall : cnt - {3'h0, cnt != 4'h0};
        // wait goes low at the edge that sees bus start, so the two-flop path still catches it
        wait_n <= !pins.bus_start_indication_n ? (stall == 4'h0) : (cnt < 4'h2);
        if (!pins.second_write_lane_n || !pins.io_write_strobe_n) begin
            last_wr <= pins.data_o[15:0];
            last_oe <= pins.data_oe[15:0];
        end
    end
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
/* self-checking bench for the card bus pin driver.
   assumes the card model and the bound checker are compiled first. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
$display("[ERR] t=%0t got %0h expected %0h", $time, (a), (b)); end end
module testbench
    import cbs_pkg::*;
();
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    logic wide_io = 1'b0;
    logic [3:0] stall = 4'h0;
    cbs_cfg_t cfg;
    cbs_req_t req;
    logic wait_n, sense_n, req_ready, done;
    logic [15:0] card_data_i, last_wr, last_oe;
    logic [DATA_W-1:0] rdata;
    cbs_pins_t pins;
    int n_mismatch = 0;
    int n_checks = 0;
    int lat;
    logic [5:0] seen;
    always #25 clk = ~clk;
    cbs_card_bus dut_u (.clk(clk), .rst_n(rst_n), .cfg(cfg), .req_valid(req_valid),
        .req(req), .wait_n(wait_n), .card_16bit_sense_n(sense_n),
        .card_data_i(card_data_i), .req_ready(req_ready), .done(done),
        .rdata(rdata), .pins(pins));
    cbs_card_model card_u (.clk(clk), .pins(pins), .stall(stall), .wide_io(wide_io),
        .wait_n(wait_n), .card_16bit_sense_n(sense_n), .card_data_i(card_data_i),
        .last_wr(last_wr), .last_oe(last_oe));
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // lat counts edges from the taking edge to the one that sees done
    task automatic run(input logic a6, wr, io, input logic [1:0] sz,
        input logic [25:0] ad, input logic [31:0] wd);
        req <= cbs_req_t'({a6, wr, io, sz, ad, wd});
        req_valid <= 1'b1;
        do @(posedge clk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        lat = 0;
        seen = '0;
        do begin
            @(posedge clk);
            lat++;
            // selects and strobes that went low at any edge of this access
            seen |= ~{pins.area_chip_selects_n[6:5], pins.rd_n, pins.second_write_lane_n,
                pins.io_read_strobe_n, pins.io_write_strobe_n};
        end while (done !== 1'b1 && lat < 100);
        if (lat >= 100) begin
            n_mismatch++;
            $display("[ERR] t=%0t access never finished", $time);
        end
    endtask
    task automatic t_pins();
        cfg.area5_card_select_bit <= 1'b0;
        cfg.area6_card_select_bit <= 1'b0;
        cfg.memory_type_field <= MEM_TYPE_ROW2;
        cfg.port_enable_bit <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK(pins.area5_second_card_enable_oe, 1'b0)
        `CHK(pins.area6_second_card_enable_oe, 1'b0)
        `CHK({pins.second_row_strobe_oe, pins.second_row_strobe_o}, 2'b11)
        `CHK(pins.data_oe[31:16], 16'hC0A5)
        `CHK(pins.data_o[31:30], 2'b10)
        cfg.area5_card_select_bit <= 1'b1;
        cfg.area6_card_select_bit <= 1'b1;
        cfg.memory_type_field <= 3'h3;
        cfg.port_enable_bit <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK(pins.second_row_strobe_oe, 1'b0)
        `CHK(pins.data_oe[31:16], 16'h0000)
        `CHK(pins.area5_second_card_enable_oe, 1'b1)
        $display("test pins finished");
    endtask
    task automatic t_lanes();
        for (int i = 0; i < 4; i++) begin
            cfg.big_endian <= i[1];
            run(1'b0, 1'b1, 1'b0, SIZE_BYTE, 26'h000_0010 | i[0], 32'h0000_005A);
            `CHK(lat, 4)
            `CHK(seen, {1'b0, !i[0], 4'b0100})
            `CHK((i[1] ^ i[0]) ? last_wr[15:8] : last_wr[7:0], 8'h5A)
        end
        cfg.big_endian <= 1'b0;
        run(1'b0, 1'b1, 1'b0, SIZE_WORD, 26'h000_0020, 32'h0000_BEEF);
        `CHK(last_wr, 16'hBEEF)
        cfg.area6_bus16 <= 1'b0;
        run(1'b1, 1'b1, 1'b0, SIZE_LONG, 26'h000_0040, 32'h4433_2211);
        `CHK(lat, 13)
        `CHK(seen, 6'h24)
        `CHK({last_oe, last_wr[7:0]}, 24'h00_FF44)
        cfg.area6_bus16 <= 1'b1;
        $display("test lanes finished");
    endtask
    task automatic t_reads();
        for (int i = 0; i < 2; i++) begin
            run(i[0], 1'b0, i[0], SIZE_WORD, 26'h000_0024, 32'h0000_0000);
            `CHK(rdata[15:0], 16'hE718)
            `CHK(seen, i[0] ? 6'h22 : 6'h18)
        end
        run(1'b1, 1'b1, 1'b1, SIZE_WORD, 26'h000_0030, 32'h0000_C0DE);
        `CHK(last_wr, 16'hC0DE)
        `CHK(seen, 6'h21)
        $display("test reads finished");
    endtask
    task automatic t_wait();
        stall <= 4'hA;
        run(1'b0, 1'b1, 1'b0, SIZE_BYTE, 26'h000_0050, 32'h0000_0011);
        `CHK(lat, 4)
        cfg.area6_wait_setting <= 3'h2;
        run(1'b1, 1'b1, 1'b0, SIZE_BYTE, 26'h000_0050, 32'h0000_0011);
        `CHK(lat > 7 && lat < 40, 1'b1)
        stall <= 4'h0;
        run(1'b1, 1'b1, 1'b0, SIZE_BYTE, 26'h000_0050, 32'h0000_0011);
        `CHK(lat, 6)
        cfg.area6_wait_setting <= 3'h0;
        $display("test wait finished");
    endtask
    task automatic t_sense();
        cfg.big_endian <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            wide_io <= (i == 1);
            repeat (3) @(posedge clk);
            run(1'b1, 1'b0, i != 2, SIZE_WORD, 26'h000_0040, 32'h0000_0000);
            `CHK(lat, (i == 0) ? 7 : 4)
            `CHK(seen, (i == 2) ? 6'h28 : 6'h22)
            `CHK(rdata[15:0], (i == 0) ? 16'h7C7D : 16'h837C)
        end
        cfg.big_endian <= 1'b0;
        $display("test sense finished");
    endtask
    initial begin
        cfg = cbs_cfg_t'(0);
        cfg.area5_bus16 = 1'b1;
        cfg.area6_bus16 = 1'b1;
        cfg.area5_card_select_bit = 1'b1;
        cfg.area6_card_select_bit = 1'b1;
        cfg.port_control_setting = 8'hA5;
        cfg.top_port_data = 2'b10;
        req = cbs_req_t'(0);
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_pins();
        t_lanes();
        t_reads();
        t_wait();
        t_sense();
        conclude();
    end
    // far beyond the hundred or so cycles the tests need
    initial begin
        #(50 * 5000);
        n_mismatch++;
        conclude();
    end
endmodule
`default_nettype wire
